/* File: core/capb_pkg.sv */
package capb_pkg;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h4;
  localparam logic [3:0] IRQ_MASK_OFFSET = 4'h8;
  localparam logic [3:0] CAPT_OFFSET = 4'hC;
  localparam int ARM_BIT = 0;
  localparam int SINGLE_PASS_BIT = 1;
  localparam int EDGE0_LSB = 2;
  localparam int EDGE1_LSB = 4;
  localparam int SRC_SEL_BIT = 6;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam int STAT_CAP0 = 0;
  localparam int STAT_CAP1 = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_W = 3;
  typedef enum logic [2:0]
  {
    SEQ_IDLE = 3'b001,
    SEQ_ARM0 = 3'b010,
    SEQ_ARM1 = 3'b100
  } seq_state_t;
endpackage

/* File: core/edge_detect.sv */
`timescale 1ns/1ps
module edge_detect
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic din,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Edges are seen only past the second stage
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule // edge_detect

/* File: core/avalon_regs.sv */
`timescale 1ns/1ps
module avalon_regs
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  output logic waitrequest,
  output logic [31:0] readdata,
  output logic rd_pulse,
  output logic wr_pulse,
  input wire logic [31:0] rd_value
);
  // One wait state: the request is served on its second cycle
  logic busy_r;
  logic wait_nxt;
  assign wait_nxt = (read | write) & ~busy_r;
  assign rd_pulse = read & busy_r;
  assign wr_pulse = write & busy_r;
  // Registered copy of the inverse of busy, so the port comes from a flop
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      busy_r <= 1'b0;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end
    else
    begin
      busy_r <= wait_nxt;
      waitrequest <= ~wait_nxt;
      if (wait_nxt && read)
        readdata <= rd_value;
    end
  end
endmodule // avalon_regs

/* File: core/capture_b_seq.sv */
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module capture_b_seq
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic waitrequest,
  output logic [31:0] readdata,
  input wire logic capture_pin,
  input wire logic counter_event,
  output logic capture0_r,
  output logic capture1_r,
  output logic armed0_r,
  output logic armed1_r,
  output logic irq_r
);
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [capb_pkg::STAT_W-1:0] stat_r;
  logic [capb_pkg::STAT_W-1:0] stat_nxt;
  logic [capb_pkg::STAT_W-1:0] mask_r;
  capb_pkg::seq_state_t state_r;
  capb_pkg::seq_state_t state_nxt;
  logic pin_rise;
  logic pin_fall;
  logic cnt_s1_r;
  logic cnt_s2_r;
  logic cnt_s3_r;
  logic rd_pulse;
  logic wr_pulse;
  logic [31:0] rd_value;

  edge_detect u_edge
  (
    .clk(clk),
    .rst_b(rst_b),
    .din(capture_pin),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  avalon_regs u_bus
  (
    .clk(clk),
    .rst_b(rst_b),
    .address(address),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .readdata(readdata),
    .rd_pulse(rd_pulse),
    .wr_pulse(wr_pulse),
    .rd_value(rd_value)
  );

  // Counter event is a pin-rate level pulse; resync and edge it
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt_s1_r <= 1'b0;
      cnt_s2_r <= 1'b0;
      cnt_s3_r <= 1'b0;
    end
    else
    begin
      cnt_s1_r <= counter_event;
      cnt_s2_r <= cnt_s1_r;
      cnt_s3_r <= cnt_s2_r;
    end
  end

  function automatic logic edge_hit(input logic [1:0] sel, input logic src_cnt,
                                    input logic rise, input logic fall, input logic cnt);
    if (sel == capb_pkg::EDGE_OFF)
      edge_hit = 1'b0;
    else if (src_cnt)
      edge_hit = cnt;
    else
      edge_hit = (sel[0] & fall) | (sel[1] & rise);
  endfunction

  wire [1:0] sel0 = ctrl_r[capb_pkg::EDGE0_LSB +: 2];
  wire [1:0] sel1 = ctrl_r[capb_pkg::EDGE1_LSB +: 2];
  wire en0 = sel0 != capb_pkg::EDGE_OFF;
  wire en1 = sel1 != capb_pkg::EDGE_OFF;
  wire arm = ctrl_r[capb_pkg::ARM_BIT];
  wire single = ctrl_r[capb_pkg::SINGLE_PASS_BIT];
  wire src_cnt = ctrl_r[capb_pkg::SRC_SEL_BIT];
  wire cnt_evt = cnt_s2_r & ~cnt_s3_r;
  logic [1:0] hit;
  logic [1:0] sel_pair [2];
  assign sel_pair[0] = sel0;
  assign sel_pair[1] = sel1;
  // One trigger decoder per capture circuit
  generate
    for (genvar k = 0; k < 2; k++)
    begin : g_circuit
      assign hit[k] = edge_hit(sel_pair[k], src_cnt, pin_rise, pin_fall, cnt_evt);
    end
  endgenerate
  wire hit0 = hit[0];
  wire hit1 = hit[1];
  function automatic logic addr_is(input logic [3:0] a, input logic [3:0] off);
    addr_is = a == off;
  endfunction
  wire ctrl_wr = wr_pulse && addr_is(address, capb_pkg::CTRL_OFFSET);
  wire mask_wr = wr_pulse && addr_is(address, capb_pkg::IRQ_MASK_OFFSET);
  // Clear when readdata is loaded, so a set after the load is not lost
  wire stat_rd = read && waitrequest && addr_is(address, capb_pkg::IRQ_STATUS_OFFSET);
  // Gated by the live arm bit so a clear stops capture at once
  wire cap0 = arm && state_r == capb_pkg::SEQ_ARM0 && hit0;
  wire cap1 = arm && state_r == capb_pkg::SEQ_ARM1 && hit1;
  // Last capture of a pass: circuit 1, or circuit 0 when alone
  wire pass_end = cap1 || (cap0 && !en1);
  wire hw_clear = single && pass_end;

  always_comb
  begin
    state_nxt = state_r;
    if (!arm)
      state_nxt = capb_pkg::SEQ_IDLE;
    else
    begin
      unique case (state_r)
        capb_pkg::SEQ_IDLE:
          if (en0)
            state_nxt = capb_pkg::SEQ_ARM0;
          else if (en1)
            state_nxt = capb_pkg::SEQ_ARM1;
        capb_pkg::SEQ_ARM0:
          if (!en0)
            state_nxt = en1 ? capb_pkg::SEQ_ARM1 : capb_pkg::SEQ_IDLE;
          else if (cap0 && en1)
            state_nxt = capb_pkg::SEQ_ARM1;
          else if (hw_clear)
            state_nxt = capb_pkg::SEQ_IDLE;
        capb_pkg::SEQ_ARM1:
          if (!en1)
            state_nxt = en0 ? capb_pkg::SEQ_ARM0 : capb_pkg::SEQ_IDLE;
          else if (hw_clear)
            state_nxt = capb_pkg::SEQ_IDLE;
          else if (cap1 && en0)
            state_nxt = capb_pkg::SEQ_ARM0;
        default:
          state_nxt = capb_pkg::SEQ_IDLE;
      endcase
    end
  end
  // a lone enabled circuit stays armed in free-running mode

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (hw_clear)
      ctrl_nxt[capb_pkg::ARM_BIT] = 1'b0;
    // Software write wins so a fresh arm after a pass is kept
    if (ctrl_wr)
      ctrl_nxt = {9'h000, writedata[6:0]};
  end

  // Status sets win over the read-clear
  always_comb
  begin
    stat_nxt = stat_rd ? {capb_pkg::STAT_W{1'b0}} : stat_r;
    if (cap0)
      stat_nxt[capb_pkg::STAT_CAP0] = 1'b1;
    if (cap1)
      stat_nxt[capb_pkg::STAT_CAP1] = 1'b1;
    if (hw_clear)
      stat_nxt[capb_pkg::STAT_DONE] = 1'b1;
  end

  always_comb
  begin
    unique case (address)
      capb_pkg::CTRL_OFFSET: rd_value = {16'h0000, ctrl_r};
      capb_pkg::IRQ_STATUS_OFFSET: rd_value = {29'h00000000, stat_r};
      capb_pkg::IRQ_MASK_OFFSET: rd_value = {29'h00000000, mask_r};
      capb_pkg::CAPT_OFFSET: rd_value = {28'h0000000, armed1_r, armed0_r, state_r == capb_pkg::SEQ_IDLE, arm};
      default: rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctrl_r <= capb_pkg::CTRL_RESET;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      stat_r <= {capb_pkg::STAT_W{1'b0}};
    end
    else
    begin
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mask_r <= {capb_pkg::STAT_W{1'b0}};
    end
    else if (mask_wr)
    begin
      mask_r <= writedata[capb_pkg::STAT_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_r <= capb_pkg::SEQ_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      capture0_r <= 1'b0;
    end
    else
    begin
      capture0_r <= cap0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      capture1_r <= 1'b0;
    end
    else
    begin
      capture1_r <= cap1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      armed0_r <= 1'b0;
    end
    else
    begin
      armed0_r <= state_nxt == capb_pkg::SEQ_ARM0 && ctrl_nxt[capb_pkg::ARM_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      armed1_r <= 1'b0;
    end
    else
    begin
      armed1_r <= state_nxt == capb_pkg::SEQ_ARM1 && ctrl_nxt[capb_pkg::ARM_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= |(stat_nxt & mask_r);
    end
  end
endmodule // capture_b_seq

/* File: tb/pin_source.sv */
`timescale 1ns/1ps
module pin_source
(
  input wire logic clk,
  input wire logic level,
  output logic pin
);
  // Driven pin, never released
  always_ff @(posedge clk)
    pin <= level;
endmodule // pin_source

/* File: tb/capture_b_seq_properties.sv */
`timescale 1ns/1ps
module capture_b_seq_properties
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic capture0_r,
  input wire logic capture1_r,
  input wire logic armed0_r,
  input wire logic armed1_r,
  input wire logic irq_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  cap0_armed_a: assert property (capture0_r |-> $past(armed0_r))
    else $error("cap0 unarmed");
  cap1_armed_a: assert property (capture1_r |-> $past(armed1_r))
    else $error("cap1 unarmed");
  arm_exclusive_a: assert property (!(armed0_r && armed1_r))
    else $error("both armed");
  pulse_exclusive_a: assert property (!(capture0_r && capture1_r))
    else $error("both captured");
  pulse_single_a: assert property (capture0_r |=> !capture0_r)
    else $error("cap0 pulse long");
  wait_one_a: assert property (!waitrequest |=> waitrequest)
    else $error("wait low too long");
  wait_cause_a: assert property (!waitrequest |-> $past(read || write))
    else $error("wait low unasked");
  reset_clean_a: assert property ($rose(rst_b) |-> !armed0_r && !armed1_r && !irq_r)
    else $error("dirty reset");
  cover property (capture0_r ##[1:40] capture1_r);
  cover property ($fell(irq_r));
  cover property ($fell(armed1_r) && !armed0_r);
endmodule // capture_b_seq_properties
bind capture_b_seq capture_b_seq_properties chk (.*);

/* File: tb/capture_b_seq_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) \
  n_checks++; \
  if ((g) !== (e)) \
  begin \
    mismatches++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); \
  end
module capture_b_seq_tb_top;
  logic clk = 0, rst_b = 0, read = 0, write = 0, want = 0, cnt_ev = 0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, pin, c0, c1, a0, a1, irq, single, arm, nxt, c, hit, m;
  logic [7:0] rnd = 8'h57;
  logic [1:0] e0, e1, got, seen;
  int mismatches = 0, n_checks = 0;
  initial forever #4 clk = ~clk;
  pin_source ps (.clk(clk), .level(want), .pin(pin));
  capture_b_seq uut (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .writedata(writedata), .waitrequest(waitrequest),
    .readdata(readdata), .capture_pin(pin), .counter_event(cnt_ev),
    .capture0_r(c0), .capture1_r(c1), .armed0_r(a0), .armed1_r(a1), .irq_r(irq));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (waitrequest !== 1'b0 && i < 20);
    if (waitrequest !== 1'b0)
    begin
      mismatches++;
      test_done;
    end
    q = readdata;
    read <= 0;
    write <= 0;
  endtask
  task toggle(output logic [1:0] g);
    g = 0;
    @(posedge clk);
    want <= !want;
    repeat (8)
    begin
      @(negedge clk);
      g |= {c1, c0};
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    bus(0, 4'h2, 0);
    `CHK("unmapped", 32'h0, q)
    for (int r = 0; r < 8; r++)
    begin
      rnd = lfsr(rnd);
      // First round is the fixed one-shot corner
      e0 = r == 0 ? 2'h1 : rnd[1:0] % 2'h3;
      e1 = r == 0 ? 2'h2 : rnd[3:2] % 2'h3;
      single = r == 0 ? 1'b1 : rnd[4];
      m = rnd[5] | (r == 0);
      bus(1, 4'h8, {29'h0, {3{m}}});
      bus(0, 4'h4, 0);
      bus(1, 4'h0, {26'h0, e1, e0, single, 1'b1});
      arm = 1;
      nxt = 0;
      seen = 0;
      repeat (6)
      begin
        toggle(got);
        c = (e0 != 0 && e1 != 0) ? nxt : (e0 == 0);
        hit = arm && ((c ? e1 : e0) == (want ? capb_pkg::EDGE_RISE : capb_pkg::EDGE_FALL));
        `CHK("captures", (hit ? {c, !c} : 2'h0), got)
        seen |= got;
        if (hit && e0 != 0 && e1 != 0)
          nxt = !nxt;
        if (hit && single && (c || e0 == 0 || e1 == 0))
          arm = 0;
      end
      `CHK("irq", (m & (seen != 0)), irq)
      bus(0, 4'h0, 0);
      `CHK("arm bit", arm, q[0])
      bus(0, 4'h4, 0);
      `CHK("status", seen, q[1:0])
      bus(1, 4'h0, 0);
      toggle(got);
      `CHK("disarmed", 2'h0, got)
      `CHK("irq clear", 1'b0, irq)
    end
    bus(1, 4'h0, {25'h0, 1'b1, 2'h0, 2'h1, 1'b1, 1'b1});
    toggle(got);
    `CHK("pin ignored", 2'h0, got)
    @(posedge clk);
    cnt_ev <= 1;
    got = 0;
    repeat (8)
    begin
      @(negedge clk);
      got |= {c1, c0};
    end
    @(posedge clk);
    cnt_ev <= 0;
    `CHK("counter src", 2'h1, got)
    bus(0, 4'h0, 0);
    `CHK("arm after cnt", 1'b0, q[0])
    test_done;
  end
endmodule // capture_b_seq_tb_top
